//--- hdl/reset_clock_startup_sequencer.sv
`timescale 1ns/1ns
`default_nettype none

module reset_clock_startup_sequencer
  import rst_seq_pkg::*;
#(
  parameter int unsigned POWER_UP_CYC  = POWER_UP_TIMER_CYC,
  parameter int unsigned POWER_ON_CYC  = POWER_ON_DELAY_CYC,
  parameter int unsigned FAST_RC_CYC   = FAST_RC_STARTUP_CYC,
  parameter int unsigned LOW_RC_CYC    = LOW_POWER_RC_CYC,
  parameter int unsigned LOCK_CYC      = PLL_LOCK_CYC,
  parameter int unsigned FAIL_MON_CYC  = CLOCK_FAIL_MON_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // reset sources, one-cycle pulses
  input  wire logic        powerOnReset,
  input  wire logic        brownOutReset,
  input  wire logic        externalResetPin,
  input  wire logic        watchdogTimeoutReset,
  input  wire logic        softwareReset,
  // selected oscillator period tick
  input  wire logic        oscPeriodTick,
  // system side
  output logic             internalSystemReset,
  output logic             codeRunEnable,
  output logic             clockFailMonitorEn,
  output logic             sysClockOpen,
  output logic      [2:0]  activeOscSel
);

  // ===========================================================
  // state
  typedef enum logic [2:0] {
    ST_BOOT  = 3'b001,
    ST_DELAY = 3'b010,
    ST_RUN   = 3'b100
  } seq_t;

  typedef struct packed {
    seq_t        state;
    logic [31:0] rstCnt;
    logic [31:0] startCnt;
    logic [9:0]  ostCnt;
    logic        useOst;
    logic        startDone;
    logic [31:0] lockCnt;
    logic [31:0] monCnt;
    logic        internal_system_reset;
    logic        run;
    logic        monEn;
    logic        clkOpen;
    logic [2:0]  oscSel;
    logic [4:0]  cause;
    logic [31:0] cfgWord;
    logic [31:0] oscCtrl;
    logic        ack;
    logic [31:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // ===========================================================
  // helpers
  logic        anyEvent;
  logic [4:0]  evCause;
  logic        isColdType;
  logic [2:0]  srcOsc;
  logic [31:0] pwrtCyc;
  logic [31:0] rdMux;
  logic        busReq;

  // event priority: power-on, brown-out, then the rest
  always_comb begin
    evCause = 5'h00;
    if (st_r.state == ST_BOOT || powerOnReset) begin
      evCause = CAUSE_POWER_ON;
    end else if (brownOutReset) begin
      evCause = CAUSE_BROWN_OUT;
    end else if (externalResetPin) begin
      evCause = CAUSE_EXT_PIN;
    end else if (watchdogTimeoutReset) begin
      evCause = CAUSE_WATCHDOG;
    end else if (softwareReset) begin
      evCause = CAUSE_SOFTWARE;
    end
  end

  assign anyEvent   = evCause != 5'h00;
  assign isColdType = evCause == CAUSE_POWER_ON || evCause == CAUSE_BROWN_OUT;
  assign busReq     = wb_cyc_i && wb_stb_i && !st_r.ack;

  // power-up timer length from the enable bit
  assign pwrtCyc = st_r.cfgWord[CFG_POWER_UP_TIMER_EN_BIT] ? 32'(POWER_UP_CYC) : 32'h0000_0000;

  // clock source chosen at this reset
  always_comb begin
    srcOsc = st_r.cfgWord[CFG_INIT_OSC_LSB +: 3];
    if (st_r.cfgWord[CFG_SWITCH_EN_BIT] && !isColdType) begin
      srcOsc = st_r.oscCtrl[CUR_OSC_LSB +: 3];
    end
    if (st_r.cfgWord[CFG_TWO_SPEED_BIT] && isColdType) begin
      srcOsc = OSC_FAST_RC;
    end
  end

  // register read mux
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (wb_adr_i)
      CONFIG_OFFSET: begin
        rdMux = st_r.cfgWord;
      end
      OSC_CTRL_OFFSET: begin
        rdMux = st_r.oscCtrl;
      end
      STATUS_OFFSET: begin
        rdMux[ST_SYS_RST_BIT]              = st_r.internal_system_reset;
        rdMux[ST_RUN_BIT]                  = st_r.run;
        rdMux[ST_FAIL_MON_BIT]             = st_r.monEn;
        rdMux[ST_CLK_OPEN_BIT]             = st_r.clkOpen;
        rdMux[ST_CAUSE_LSB +: 5]           = st_r.cause;
        rdMux[ST_ACTIVE_OSC_LSB +: 3]      = st_r.oscSel;
      end
      default: begin
        rdMux = 32'h0000_0000;
      end
    endcase
  end

  // ===========================================================
  // next state
  always_comb begin
    st_nxt = st_r;

    // bus slave: ack one cycle after request, drop next cycle
    st_nxt.ack = busReq;
    if (busReq) begin
      st_nxt.rdata = rdMux;
      if (wb_we_i && wb_adr_i == CONFIG_OFFSET) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            st_nxt.cfgWord[b*8 +: 8] = wb_dat_i[b*8 +: 8] & CONFIG_MASK[b*8 +: 8];
          end
        end
      end
      if (wb_we_i && wb_adr_i == OSC_CTRL_OFFSET && wb_sel_i[1]) begin
        st_nxt.oscCtrl[CUR_OSC_LSB +: 3] = wb_dat_i[CUR_OSC_LSB +: 3];
      end
    end

    unique case (st_r.state)
      ST_BOOT: begin
        st_nxt.state = ST_DELAY;
      end
      ST_DELAY: begin
        // reset delay counts alongside clock delay
        if (st_r.rstCnt != 32'h0000_0000) begin
          st_nxt.rstCnt = st_r.rstCnt - 32'h0000_0001;
        end else begin
          st_nxt.internal_system_reset = 1'b0;
        end
        // first stage: RC start-up or oscillator start-up count
        if (!st_r.startDone) begin
          if (st_r.useOst) begin
            if (oscPeriodTick) begin
              st_nxt.ostCnt = st_r.ostCnt + 10'h001;
              if (st_r.ostCnt == OSC_STARTUP_LAST) begin
                st_nxt.startDone = 1'b1;
              end
            end
          end else if (st_r.startCnt != 32'h0000_0000) begin
            st_nxt.startCnt = st_r.startCnt - 32'h0000_0001;
          end else begin
            st_nxt.startDone = 1'b1;
          end
        end else if (st_r.lockCnt != 32'h0000_0000) begin
          st_nxt.lockCnt = st_r.lockCnt - 32'h0000_0001;
        end else begin
          st_nxt.clkOpen = 1'b1;
        end
        // reset released: start monitor delay, wait for clock
        if (!st_r.internal_system_reset) begin
          if (st_r.monCnt != 32'h0000_0000) begin
            st_nxt.monCnt = st_r.monCnt - 32'h0000_0001;
          end else begin
            st_nxt.monEn = 1'b1;
          end
          if (st_r.clkOpen) begin
            st_nxt.state = ST_RUN;
            st_nxt.run   = 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (st_r.monCnt != 32'h0000_0000) begin
          st_nxt.monCnt = st_r.monCnt - 32'h0000_0001;
        end else begin
          st_nxt.monEn = 1'b1;
        end
      end
    endcase

    // any reset event restarts all counters and the system-side outputs and gates the clock
    if (anyEvent) begin
      st_nxt.state     = ST_DELAY;
      st_nxt.internal_system_reset    = 1'b1;
      st_nxt.run       = 1'b0;
      st_nxt.monEn     = 1'b0;
      st_nxt.clkOpen   = 1'b0;
      st_nxt.cause     = evCause;
      st_nxt.oscSel    = srcOsc;
      st_nxt.oscCtrl[CUR_OSC_LSB +: 3] = srcOsc;
      st_nxt.monCnt    = 32'(FAIL_MON_CYC);
      st_nxt.ostCnt    = 10'h000;
      st_nxt.startDone = 1'b0;
      st_nxt.useOst    = 1'b0;
      st_nxt.startCnt  = 32'h0000_0000;
      st_nxt.lockCnt   = 32'h0000_0000;
      // reset delay by reset type
      unique case (evCause)
        CAUSE_POWER_ON: begin
          st_nxt.rstCnt = 32'(POWER_ON_CYC) + pwrtCyc;
        end
        CAUSE_BROWN_OUT: begin
          st_nxt.rstCnt = pwrtCyc;
        end
        default: begin
          st_nxt.rstCnt = 32'h0000_0000;
        end
      endcase
      // clock delay by source
      unique case (osc_t'(srcOsc))
        OSC_FAST_RC, OSC_FAST_RC_PLL: begin
          st_nxt.startCnt = 32'(FAST_RC_CYC);
        end
        OSC_LOW_POWER_RC: begin
          st_nxt.startCnt = 32'(LOW_RC_CYC);
        end
        OSC_CRYSTAL, OSC_CRYSTAL_PLL, OSC_SECONDARY: begin
          st_nxt.useOst = 1'b1;
        end
        OSC_EXT_CLOCK, OSC_EXT_CLK_PLL: begin
          st_nxt.startCnt = 32'h0000_0000;
        end
      endcase
      if (srcOsc == OSC_FAST_RC_PLL || srcOsc == OSC_EXT_CLK_PLL ||
          srcOsc == OSC_CRYSTAL_PLL) begin
        st_nxt.lockCnt = 32'(LOCK_CYC);
      end
    end
  end

  // ===========================================================
  // state register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r.state     <= ST_BOOT;
      st_r.rstCnt    <= 32'h0000_0000;
      st_r.startCnt  <= 32'h0000_0000;
      st_r.ostCnt    <= 10'h000;
      st_r.useOst    <= 1'b0;
      st_r.startDone <= 1'b0;
      st_r.lockCnt   <= 32'h0000_0000;
      st_r.monCnt    <= 32'h0000_0000;
      st_r.internal_system_reset    <= 1'b1;
      st_r.run       <= 1'b0;
      st_r.monEn     <= 1'b0;
      st_r.clkOpen   <= 1'b0;
      st_r.oscSel    <= 3'h0;
      st_r.cause     <= 5'h00;
      st_r.cfgWord   <= CONFIG_RESET;
      st_r.oscCtrl   <= OSC_CTRL_RESET;
      st_r.ack       <= 1'b0;
      st_r.rdata     <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign wb_ack_o            = st_r.ack;
  assign wb_dat_o            = st_r.rdata;
  assign internalSystemReset = st_r.internal_system_reset;
  assign codeRunEnable       = st_r.run;
  assign clockFailMonitorEn  = st_r.monEn;
  assign sysClockOpen        = st_r.clkOpen;
  assign activeOscSel        = st_r.oscSel;

endmodule

`default_nettype wire

//--- hdl/rst_seq_pkg.sv
package rst_seq_pkg;

  // ===========================================================
  // clock and timing
  localparam int unsigned CLK_MHZ              = 100;
  localparam int unsigned POWER_UP_TIMER_MS    = 64;
  localparam int unsigned POWER_ON_DELAY_US    = 50;
  localparam int unsigned FAST_RC_STARTUP_US   = 15;
  localparam int unsigned LOW_POWER_RC_STARTUP_US = 100;
  localparam int unsigned PLL_LOCK_US          = 128;
  localparam int unsigned CLOCK_FAIL_MON_US    = 10;
  localparam int unsigned POWER_UP_TIMER_CYC   = POWER_UP_TIMER_MS * 1000 * CLK_MHZ;
  localparam int unsigned POWER_ON_DELAY_CYC   = POWER_ON_DELAY_US * CLK_MHZ;
  localparam int unsigned FAST_RC_STARTUP_CYC  = FAST_RC_STARTUP_US * CLK_MHZ;
  localparam int unsigned LOW_POWER_RC_CYC     = LOW_POWER_RC_STARTUP_US * CLK_MHZ;
  localparam int unsigned PLL_LOCK_CYC         = PLL_LOCK_US * CLK_MHZ;
  localparam int unsigned CLOCK_FAIL_MON_CYC   = CLOCK_FAIL_MON_US * CLK_MHZ;
  localparam logic [9:0]  OSC_STARTUP_LAST     = 10'h3FF;

  // ===========================================================
  // oscillator source codes
  typedef enum logic [2:0] {
    OSC_FAST_RC      = 3'h0,
    OSC_FAST_RC_PLL  = 3'h1,
    OSC_EXT_CLOCK    = 3'h2,
    OSC_EXT_CLK_PLL  = 3'h3,
    OSC_CRYSTAL      = 3'h4,
    OSC_CRYSTAL_PLL  = 3'h5,
    OSC_SECONDARY    = 3'h6,
    OSC_LOW_POWER_RC = 3'h7
  } osc_t;

  // ===========================================================
  // register map
  localparam logic [7:0] CONFIG_OFFSET  = 8'h00;
  localparam logic [7:0] OSC_CTRL_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET  = 8'h08;

  // config fields
  localparam int unsigned CFG_SWITCH_EN_BIT = 0;
  localparam int unsigned CFG_POWER_UP_TIMER_EN_BIT   = 1;
  localparam int unsigned CFG_TWO_SPEED_BIT = 2;
  localparam int unsigned CFG_INIT_OSC_LSB  = 4;
  localparam logic [31:0] CONFIG_RESET      = 32'h0000_0042;
  localparam logic [31:0] CONFIG_MASK       = 32'h0000_0077;

  // oscillator control fields
  localparam int unsigned CUR_OSC_LSB       = 12;
  localparam logic [31:0] OSC_CTRL_RESET    = 32'h0000_4000;

  // status fields
  localparam int unsigned ST_SYS_RST_BIT    = 0;
  localparam int unsigned ST_RUN_BIT        = 1;
  localparam int unsigned ST_FAIL_MON_BIT   = 2;
  localparam int unsigned ST_CLK_OPEN_BIT   = 3;
  localparam int unsigned ST_CAUSE_LSB      = 4;
  localparam int unsigned ST_ACTIVE_OSC_LSB = 12;

  // reset cause codes (one-hot)
  localparam logic [4:0] CAUSE_POWER_ON  = 5'h01;
  localparam logic [4:0] CAUSE_BROWN_OUT = 5'h02;
  localparam logic [4:0] CAUSE_EXT_PIN   = 5'h04;
  localparam logic [4:0] CAUSE_WATCHDOG  = 5'h08;
  localparam logic [4:0] CAUSE_SOFTWARE  = 5'h10;

endpackage

//--- tb/reset_seq_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ===========================================================
// port-level checks
module reset_seq_sva #(
  parameter int unsigned FAIL_MON_CYC = 4
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // bus
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // reset events
  input wire logic       powerOnReset,
  input wire logic       brownOutReset,
  input wire logic       externalResetPin,
  input wire logic       watchdogTimeoutReset,
  input wire logic       softwareReset,
  // system side
  input wire logic       internalSystemReset,
  input wire logic       codeRunEnable,
  input wire logic       clockFailMonitorEn,
  input wire logic       sysClockOpen,
  input wire logic [2:0] activeOscSel
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // any event, and the events with no delay
  wire lateEvt = externalResetPin | watchdogTimeoutReset | softwareReset;
  wire anyEvt  = lateEvt | powerOnReset | brownOutReset;

  evt_gate_a: assert property (anyEvt |=> internalSystemReset && !sysClockOpen
    && !codeRunEnable && !clockFailMonitorEn) else $error("event did not gate outputs");
  run_gate_a: assert property (codeRunEnable |-> !internalSystemReset && sysClockOpen)
    else $error("code ran too early");
  mon_hold_a: assert property (clockFailMonitorEn |-> !$past(internalSystemReset, FAIL_MON_CYC))
    else $error("monitor started early");
  mon_late_a: assert property ($fell(internalSystemReset) && !anyEvt ##1 !anyEvt[*6]
    |=> clockFailMonitorEn) else $error("monitor never started");
  fast_rel_a: assert property (lateEvt && !powerOnReset && !brownOutReset ##1 !anyEvt
    |=> !internalSystemReset) else $error("reset held too long");
  osc_hold_a: assert property (!anyEvt && $past(reset_n, 2) |=> $stable(activeOscSel))
    else $error("source changed without reset");
  open_drop_a: assert property ($fell(sysClockOpen) |-> $past(anyEvt))
    else $error("clock closed without reset");
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no bus ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");

  // main scenarios
  cover property (softwareReset);
  cover property ($rose(codeRunEnable));
  cover property ($rose(clockFailMonitorEn));
endmodule

bind reset_clock_startup_sequencer reset_seq_sva #(.FAIL_MON_CYC(FAIL_MON_CYC)) u_sva (
  .clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .powerOnReset, .brownOutReset,
  .externalResetPin, .watchdogTimeoutReset, .softwareReset, .internalSystemReset,
  .codeRunEnable, .clockFailMonitorEn, .sysClockOpen, .activeOscSel);
`default_nettype wire

//--- tb/osc_tick_model.sv
`timescale 1ns/1ns
`default_nettype none
// ===========================================================
// selected oscillator, one tick per DIV system cycles
module osc_tick_model #(
  parameter int DIV = 3
) (
  // clock and control
  input  wire logic clk_sys,
  input  wire logic run,
  // period tick
  output logic      tick
);
  int cnt = 0;
  // stopped oscillator gives no ticks
  always @(posedge clk_sys) begin
    cnt  <= run ? (cnt + 1) % DIV : 0;
    tick <= run && cnt == DIV - 1;
  end
endmodule
`default_nettype wire

//--- tb/reset_clock_startup_sequencer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module reset_clock_startup_sequencer_tb_top;
  import rst_seq_pkg::*;
  // ===========================================================
  // signals
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic        tickRun = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [4:0]  evt = 5'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] rdat;
  logic        ack, tick, isr, run, mon, open;
  logic [2:0]  osc;
  int          n_fail = 0;
  int          comparisons = 0;
  int          n;
  // ===========================================================
  // clock, oscillator and design
  initial forever #5 clk_sys = ~clk_sys;
  // oscillator ticks every third cycle, its default divider
  osc_tick_model osc_m (.clk_sys, .run(tickRun), .tick);
  // slow rc keeps its full default start-up time
  reset_clock_startup_sequencer #(.POWER_UP_CYC(50), .POWER_ON_CYC(20), .FAST_RC_CYC(5),
    .LOCK_CYC(9), .FAIL_MON_CYC(4)) dut (
    .clk_sys, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .powerOnReset(evt[0]), .brownOutReset(evt[1]), .externalResetPin(evt[2]),
    .watchdogTimeoutReset(evt[3]), .softwareReset(evt[4]), .oscPeriodTick(tick),
    .internalSystemReset(isr), .codeRunEnable(run), .clockFailMonitorEn(mon),
    .sysClockOpen(open), .activeOscSel(osc));
  // ===========================================================
  // shared tasks
  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic timeout(input int i, input int lim);
    if (i >= lim) begin
      n_fail++;
      $display("Error at %0t: wait timed out", $time);
      wrap_up();
    end
  endtask
  // one classic cycle, held until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (ack === 1'b1) break;
    end
    timeout(i, 20);
    cyc <= 1'b0;
  endtask
  task automatic pulse(input int k);
    @(posedge clk_sys);
    evt[k] <= 1'b1;
    @(posedge clk_sys);
    evt <= 5'h00;
  endtask
  // negedges until s reaches v, from the second one on
  task automatic dur(ref logic s, input logic v);
    for (n = 1; n < 4000; n++) begin
      @(negedge clk_sys);
      if (n > 1 && s === v) break;
    end
    timeout(n, 4000);
  endtask
  // ===========================================================
  // scenarios
  task automatic t_boot;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    dur(isr, 1'b0);
    check(32'(n >= 72 && n <= 75), 32'h1);
    check(32'(osc), 32'(OSC_CRYSTAL));
  endtask
  task automatic t_regs;
    wb(1'b0, CONFIG_OFFSET, 32'h0);
    check(rdat, CONFIG_RESET);
    wb(1'b1, CONFIG_OFFSET, 32'hFFFF_FFFF);
    // writes with no byte enabled leave both registers alone
    sel <= 4'h0;
    wb(1'b1, CONFIG_OFFSET, 32'h0);
    wb(1'b1, OSC_CTRL_OFFSET, 32'h0);
    sel <= 4'hF;
    wb(1'b0, CONFIG_OFFSET, 32'h0);
    check(rdat, CONFIG_MASK);
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h0C, 32'h0);
    check(rdat, 32'h0);
    wb(1'b0, OSC_CTRL_OFFSET, 32'h0);
    check(rdat, OSC_CTRL_RESET);
    wb(1'b0, STATUS_OFFSET, 32'h0);
    check(rdat, (32'(CAUSE_POWER_ON) << ST_CAUSE_LSB) | (32'h1 << ST_FAIL_MON_BIT)
      | (32'(OSC_CRYSTAL) << ST_ACTIVE_OSC_LSB));
  endtask
  // pin, watchdog, software: no delay, current source
  task automatic t_walk;
    int k, i;
    wb(1'b1, CONFIG_OFFSET, 32'h01);
    wb(1'b1, OSC_CTRL_OFFSET, 32'h2000);
    for (k = 2; k <= 4; k++) begin
      pulse(k);
      for (i = 1; i <= 8; i++) begin
        @(negedge clk_sys);
        check(32'({isr, open, run, mon}), 32'({i == 1, i > 2, i > 3, i > 6}));
      end
      check(32'(osc), 32'(OSC_EXT_CLOCK));
    end
  endtask
  task automatic t_bor;
    wb(1'b1, CONFIG_OFFSET, 32'h03);
    pulse(1);
    dur(isr, 1'b0);
    check(32'(n), 32'd52);
    check(32'(osc), 32'(OSC_FAST_RC));
  endtask
  // crystal stopped: only the fast RC can start
  task automatic t_twospeed;
    wb(1'b1, CONFIG_OFFSET, 32'h44);
    tickRun <= 1'b0;
    pulse(0);
    dur(isr, 1'b0);
    check(32'(n), 32'd22);
    dur(run, 1'b1);
    check(32'(n <= 3), 32'h1);
    check(32'(osc), 32'(OSC_FAST_RC));
  endtask
  task automatic t_restart;
    tickRun <= 1'b1;
    pulse(4);
    repeat (100) @(negedge clk_sys);
    check(32'({open, run}), 32'h0);
    check(32'(osc), 32'(OSC_CRYSTAL));
    pulse(3);
    dur(open, 1'b1);
    check(32'(n >= 3066 && n <= 3082), 32'h1);
  endtask
  // pll lock after an external clock, then the slow rc on its full time
  task automatic t_lock;
    wb(1'b1, CONFIG_OFFSET, 32'h01);
    wb(1'b1, OSC_CTRL_OFFSET, 32'h3000);
    pulse(2);
    dur(open, 1'b1);
    check(32'(n), 32'd12);
    check(32'(osc), 32'(OSC_EXT_CLK_PLL));
    wb(1'b1, OSC_CTRL_OFFSET, 32'h7000);
    pulse(4);
    repeat (LOW_POWER_RC_CYC) @(negedge clk_sys);
    check(32'(open), 32'h0);
    dur(open, 1'b1);
    check(32'(n), 32'd3);
    check(32'(osc), 32'(OSC_LOW_POWER_RC));
  endtask
  // ===========================================================
  // main sequence
  initial begin
    t_boot();
    t_regs();
    t_walk();
    t_bor();
    t_twospeed();
    t_restart();
    t_lock();
    wrap_up();
  end
endmodule
`default_nettype wire
